// file: rtl/usm_sync_top.sv
// Operation
// R1 - Software: enable, break, dummy write, sync byte
// R2 - Break done clears send-break, sends queued byte
// R3 - Empty transmit holding register raises empty flag
// R4 - Zero character without stop sets framing flag
// R5 - Wake watches two edges, flags, then receives
// R6 - Two wires, half duplex, never both ways
// R7 - Synchronous characters carry no start, stop
// R8 - Master select; receive enables pick direction
// R9 - Master drives clock; data changes leading edge
// R10 - One clock cycle per data bit only
// R11 - Polarity sets clock idle level and edge
// R12 - Master transmit drives data and clock pins
// R13 - Holding waits while shifting, else loads
// R14 - Master receive releases data pin
// R15 - Single receive clocks one character, self-clears
// R16 - Continuous receive stops at once when cleared
// R17 - Both set: single clears, continuous continues
// R18 - Trailing edge sampling into two-entry queue
// R19 - Slave takes clock pin, driver off
// R20 - Third character while full sets overrun
// R21 - Overrun clears by read or receive disable
// R22 - Ninth bit shown separately, read first
// R23 - Break is start, twelve zeros, stop
// R24 - Reading received data pops the queue
`timescale 1ns/1ps
`default_nettype none
module usm_sync_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [usm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ck_i,
  output logic ck_o,
  output logic ck_oe_o,
  input wire logic dt_i,
  output logic dt_o,
  output logic dt_oe_o
);
  import usm_pkg::*;

  typedef struct packed {
    logic [7:0] baud_control_reg;
    logic [7:0] rx_status_control_reg;
    logic [7:0] tx_status_control_reg;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] tx_data_reg;
    logic tx_full;
    usm_state_t st;
    logic [13:0] tx_shift_reg;
    logic [8:0] rx_shift_reg;
    logic [3:0] nb;
    logic [3:0] bcnt;
    logic [15:0] bd;
    logic ph;
    logic first;
    logic brk;
    logic wake;
    logic overrun_error_flag;
    logic overrun_single;
    logic ck_m;
    logic ck_s;
    logic ck_p;
    logic dt_m;
    logic dt_s;
    logic dt_p;
    logic ck;
    logic ck_oe;
    logic dt;
    logic dt_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } usm_regs_t;

  usm_regs_t s;
  usm_regs_t n;

  usm_fifo_if #(.W(FIFO_W)) fif ();

  usm_rx_fifo #(.W(FIFO_W)) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .f(fif.store)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [8:0] word_of(input logic nine, input logic [8:0] r);
    return nine ? r : {1'b0, r[8:1]};
  endfunction : word_of

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  logic serial_port_enable;
  logic sync_mode;
  logic clock_source_select;
  logic master;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic transmit_enable;
  logic send_break_ctl;
  logic clock_polarity_select;
  logic wake_on_break_enable;
  logic rx_nine_bit_enable;
  logic tx_nine_bit_enable;
  logic tick;
  logic ck_lead;
  logic ck_trail;
  logic lead_ev;
  logic trail_ev;
  logic do_push;
  logic [9:0] push_word;
  logic wr_acc;

  assign serial_port_enable = s.rx_status_control_reg[RC_PORT_EN];
  assign rx_nine_bit_enable = s.rx_status_control_reg[RC_RX_NINE];
  assign single_receive_enable = s.rx_status_control_reg[RC_SINGLE_RX];
  assign continuous_receive_enable = s.rx_status_control_reg[RC_CONT_RX];
  assign sync_mode = s.tx_status_control_reg[TC_SYNC_MODE];
  assign clock_source_select = s.tx_status_control_reg[TC_CLK_SRC];
  assign transmit_enable = s.tx_status_control_reg[TC_TX_ENABLE];
  assign send_break_ctl = s.tx_status_control_reg[TC_SEND_BREAK];
  assign tx_nine_bit_enable = s.tx_status_control_reg[TC_TX_NINE];
  assign clock_polarity_select = s.baud_control_reg[BC_POLARITY];
  assign wake_on_break_enable = s.baud_control_reg[BC_WAKE];
  assign master = sync_mode & clock_source_select; // see R8
  assign tick = (s.bd == {s.baud_divisor_high, s.baud_divisor_low});
  // Slave edges come from the synchronised pin, never from its first stage
  assign ck_lead = (s.ck_s != s.ck_p) && (s.ck_s != clock_polarity_select); // see R19
  assign ck_trail = (s.ck_s != s.ck_p) && (s.ck_s == clock_polarity_select);
  assign lead_ev = (master || !sync_mode) ? (tick && !s.ph) : ck_lead;
  assign trail_ev = (master || !sync_mode) ? (tick && s.ph) : ck_trail;
  assign wr_acc = psel_i && penable_i && pwrite_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] rd;
    logic [8:0] shifted;
    rd = 8'h00;
    shifted = {s.dt_s, s.rx_shift_reg[8:1]};
    n = s;
    do_push = 1'b0;
    push_word = '0;
    fif.push = 1'b0;
    fif.pop = 1'b0;
    fif.clr = 1'b0;
    fif.wdata = '0;
    n.pready = 1'b1;
    n.ck_m = ck_i;
    n.ck_s = s.ck_m;
    n.ck_p = s.ck_s;
    n.dt_m = dt_i;
    n.dt_s = s.dt_m;
    n.dt_p = s.dt_s;

    // Read data is captured in the setup phase so the access phase is zero wait
    if (psel_i && !penable_i) begin
      n.pslverr = 1'b0;
      if (hit(paddr_i, OFF_BAUD_CONTROL)) begin
        rd = s.baud_control_reg & BC_WMASK;
        rd[BC_RX_IDLE] = (s.st != ST_RX);
      end else if (hit(paddr_i, OFF_RX_STATUS_CONTROL)) begin
        rd = s.rx_status_control_reg & RC_WMASK;
        rd[RC_OVERRUN] = s.overrun_error_flag;
        rd[RC_FRAMING] = (fif.count != 2'h0) && fif.top[FE_FRAMING]; // see R4
        rd[RC_NINTH_BIT] = (fif.count != 2'h0) && fif.top[8]; // see R22
      end else if (hit(paddr_i, OFF_BAUD_DIVISOR_LOW)) begin
        rd = s.baud_divisor_low;
      end else if (hit(paddr_i, OFF_BAUD_DIVISOR_HIGH)) begin
        rd = s.baud_divisor_high;
      end else if (hit(paddr_i, OFF_TX_DATA)) begin
        rd = 8'h00;
      end else if (hit(paddr_i, OFF_TX_STATUS_CONTROL)) begin
        rd = s.tx_status_control_reg & TC_WMASK;
        rd[TC_SHIFT_EMPTY] = (s.st != ST_TX);
      end else if (hit(paddr_i, OFF_RX_DATA)) begin
        rd = (fif.count != 2'h0) ? fif.top[7:0] : 8'h00;
      end else if (hit(paddr_i, OFF_FLAGS)) begin
        rd[FL_TX_EMPTY] = !s.tx_full; // see R3
        rd[FL_RX_CHAR] = (fif.count != 2'h0) || s.wake; // see R18
      end else begin
        n.pslverr = 1'b1;
      end
      n.prdata = {24'h000000, rd};
    end

    // Software writes go first so hardware updates below win the same cycle
    if (wr_acc) begin
      if (hit(paddr_i, OFF_BAUD_CONTROL)) begin
        n.baud_control_reg = pwdata_i[7:0] & BC_WMASK;
      end else if (hit(paddr_i, OFF_RX_STATUS_CONTROL)) begin
        n.rx_status_control_reg = pwdata_i[7:0] & RC_WMASK;
        if (!pwdata_i[RC_CONT_RX] && s.overrun_error_flag && !s.overrun_single) begin
          n.overrun_error_flag = 1'b0; // see R21
        end
      end else if (hit(paddr_i, OFF_BAUD_DIVISOR_LOW)) begin
        n.baud_divisor_low = pwdata_i[7:0];
      end else if (hit(paddr_i, OFF_BAUD_DIVISOR_HIGH)) begin
        n.baud_divisor_high = pwdata_i[7:0];
      end else if (hit(paddr_i, OFF_TX_STATUS_CONTROL)) begin
        n.tx_status_control_reg = pwdata_i[7:0] & TC_WMASK;
      end
    end else if (psel_i && penable_i && hit(paddr_i, OFF_RX_DATA)) begin
      fif.pop = (fif.count != 2'h0); // see R24
      n.wake = 1'b0;
      if (s.overrun_error_flag && s.overrun_single) begin
        n.overrun_error_flag = 1'b0; // see R21
      end
    end

    // Bit timer runs only while a character is on the wire
    if (s.st == ST_TX || s.st == ST_RX) begin
      if (tick) begin
        n.bd = '0;
        n.ph = !s.ph;
      end else begin
        n.bd = s.bd + 16'h0001;
      end
    end

    if (!serial_port_enable) begin
      n.st = ST_IDLE;
      n.tx_full = 1'b0;
      n.overrun_error_flag = 1'b0; // see R21
      n.wake = 1'b0;
      n.brk = 1'b0;
      n.ck_oe = 1'b0;
      n.dt_oe = 1'b0;
      fif.clr = 1'b1;
    end else begin
      case (s.st)
        ST_IDLE: begin
          n.bd = '0;
          n.ph = 1'b0;
          n.bcnt = 4'h0;
          n.first = 1'b0;
          n.ck_oe = master; // see R9 R19
          n.ck = clock_polarity_select; // see R11
          n.dt_oe = transmit_enable && !(sync_mode &&
                    (single_receive_enable || continuous_receive_enable)); // see R12 R14
          n.dt = sync_mode ? s.dt : 1'b1;
          if (wake_on_break_enable && !sync_mode) begin
            n.st = ST_WAKE; // see R5
          end else if (!s.overrun_error_flag && sync_mode && (master ?
                       (single_receive_enable || continuous_receive_enable) :
                       continuous_receive_enable)) begin
            // Receive has priority; the data pin is never driven while receiving
            n.st = ST_RX; // see R6 R8
            n.dt_oe = 1'b0; // see R14
            n.nb = rx_nine_bit_enable ? BITS_9 : BITS_8;
            if (master) begin
              n.ck = !clock_polarity_select; // see R15 R16
              n.ph = 1'b1;
            end
          end else if (!s.overrun_error_flag && !sync_mode && continuous_receive_enable &&
                       s.dt_p && !s.dt_s) begin
            n.st = ST_RX;
            n.first = 1'b1;
            n.nb = rx_nine_bit_enable ? BITS_9 : BITS_8;
          end else if (transmit_enable && s.tx_full) begin
            n.tx_full = 1'b0; // see R3 R13
            n.st = ST_TX;
            n.ph = 1'b1;
            n.first = sync_mode && !clock_source_select;
            if (!sync_mode && send_break_ctl) begin
              n.tx_shift_reg = BRK_FRAME; // see R23
              n.nb = BRK_BITS;
              n.brk = 1'b1;
            end else if (!sync_mode) begin
              n.tx_shift_reg = tx_nine_bit_enable ?
                {3'h0, 1'b1, s.tx_status_control_reg[TC_TX_NINTH_BIT], s.tx_data_reg, 1'b0} :
                {4'h0, 1'b1, s.tx_data_reg, 1'b0};
              n.nb = tx_nine_bit_enable ? ASYNC_BITS_9 : ASYNC_BITS_8;
            end else begin
              // No start or stop framing on the synchronous wire
              n.tx_shift_reg = {5'h00, s.tx_status_control_reg[TC_TX_NINTH_BIT],
                                s.tx_data_reg}; // see R7
              n.nb = tx_nine_bit_enable ? BITS_9 : BITS_8;
            end
            n.dt = n.tx_shift_reg[0];
            if (master) begin
              n.ck = !clock_polarity_select; // see R9
            end
          end
        end
        ST_TX: begin
          if (trail_ev) begin
            if (master) begin
              n.ck = clock_polarity_select;
            end
            n.bcnt = s.bcnt + 4'h1;
            if (sync_mode && !clock_source_select && s.bcnt == s.nb - 4'h1) begin
              n.st = ST_IDLE;
            end
          end else if (lead_ev) begin
            if (s.first) begin
              n.first = 1'b0;
            end else if (s.bcnt == s.nb) begin
              // A half period at the idle level separates back-to-back characters
              n.st = ST_IDLE; // see R10
              n.dt = sync_mode ? s.dt : 1'b1;
              if (s.brk) begin
                n.tx_status_control_reg[TC_SEND_BREAK] = 1'b0; // see R2
                n.brk = 1'b0;
              end
            end else begin
              n.tx_shift_reg = s.tx_shift_reg >> 1;
              n.dt = s.tx_shift_reg[1]; // see R9
              if (master) begin
                n.ck = !clock_polarity_select; // see R10 R11
              end
            end
          end
        end
        ST_RX: begin
          if (sync_mode && !(n.rx_status_control_reg[RC_SINGLE_RX] ||
                             n.rx_status_control_reg[RC_CONT_RX])) begin
            n.st = ST_IDLE; // see R16
            n.ck = clock_polarity_select;
          end else if (!sync_mode) begin
            if (lead_ev) begin
              if (s.first) begin
                n.first = 1'b0;
                if (s.dt_s) begin
                  n.st = ST_IDLE;
                end
              end else if (s.bcnt == s.nb) begin
                do_push = 1'b1; // see R4
                push_word = {!s.dt_s, word_of(rx_nine_bit_enable, s.rx_shift_reg)};
                n.st = ST_IDLE;
              end else begin
                n.rx_shift_reg = shifted;
                n.bcnt = s.bcnt + 4'h1;
              end
            end
          end else if (trail_ev) begin
            if (master) begin
              n.ck = clock_polarity_select;
            end
            n.rx_shift_reg = shifted; // see R18
            n.bcnt = s.bcnt + 4'h1;
            if (s.bcnt == s.nb - 4'h1) begin
              do_push = 1'b1;
              push_word = {1'b0, word_of(rx_nine_bit_enable, shifted)}; // see R22
              if (master) begin
                n.rx_status_control_reg[RC_SINGLE_RX] = 1'b0; // see R15 R17
              end else begin
                n.st = ST_IDLE;
              end
            end
          end else if (lead_ev && master) begin
            if (s.bcnt == s.nb) begin
              n.st = ST_IDLE;
            end else begin
              n.ck = !clock_polarity_select;
            end
          end
        end
        ST_WAKE: begin
          if (!s.ph && s.dt_p && !s.dt_s) begin
            n.wake = 1'b1; // see R5
            n.ph = 1'b1;
          end else if (s.ph && !s.dt_p && s.dt_s) begin
            n.baud_control_reg[BC_WAKE] = 1'b0;
            n.st = ST_IDLE;
          end
          if (!wake_on_break_enable) begin
            n.st = ST_IDLE;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end

    // A full queue keeps its contents; the newcomer only raises overrun
    if (do_push) begin
      if (fif.count == FIFO_DEPTH && !fif.pop) begin
        n.overrun_error_flag = 1'b1; // see R20
        n.overrun_single = single_receive_enable && !continuous_receive_enable;
      end else begin
        fif.push = 1'b1; // see R18
        fif.wdata = push_word;
      end
    end

    // Late so that a load this cycle frees the holding register for the new byte
    if (wr_acc && hit(paddr_i, OFF_TX_DATA) && serial_port_enable && transmit_enable &&
        !n.tx_full) begin
      n.tx_data_reg = pwdata_i[7:0]; // see R13
      n.tx_full = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign ck_o = s.ck;
  assign ck_oe_o = s.ck_oe;
  assign dt_o = s.dt;
  assign dt_oe_o = s.dt_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence sq_break_end;
    (s.st == ST_TX && s.brk) ##1 (s.st == ST_IDLE);
  endsequence

  sequence sq_async_load;
    serial_port_enable && s.st == ST_IDLE && transmit_enable && s.tx_full && !sync_mode &&
    !continuous_receive_enable && !wake_on_break_enable;
  endsequence

  break_send_break_ctl_a: assert property (sq_break_end |-> !send_break_ctl) // see R2
    else $error("send-break not cleared after break");
  tx_load_a: assert property (sq_async_load |=> (s.st == ST_TX && !s.tx_full)) // see R13
    else $error("holding byte not moved to shifter");
  half_duplex_a: assert property ((s.st == ST_RX && sync_mode) |-> !s.dt_oe) // see R6
    else $error("data pin driven while receiving");
  ck_idle_a: assert property ((serial_port_enable && $past(serial_port_enable) && // see R11
    s.st == ST_IDLE && $past(s.st) == ST_IDLE && $stable(clock_polarity_select)) |->
    s.ck == clock_polarity_select)
    else $error("clock not at idle level");
  data_lead_a: assert property ((master && s.st == ST_TX && $past(s.st) == ST_TX && // see R9
    $changed(s.dt)) |-> s.ck != clock_polarity_select)
    else $error("data changed away from leading edge");
  overrun_full_a: assert property ($rose(s.overrun_error_flag) |-> // see R20
    fif.count == FIFO_DEPTH)
    else $error("overrun without full queue");
  single_clr_a: assert property ((do_push && master && s.st == ST_RX && !wr_acc) |=> // see R15
    !single_receive_enable)
    else $error("single receive not cleared");
  continuous_receive_enable_stop_a: assert property ((sync_mode && serial_port_enable && // see R16
    $fell(continuous_receive_enable) && !single_receive_enable &&
    $past(s.st) == ST_RX) |-> s.st == ST_IDLE)
    else $error("clock did not stop on receive disable");
  pop_a: assert property ((fif.pop && !fif.push && fif.count == FIFO_DEPTH) |=> // see R24
    fif.count == 2'h1)
    else $error("read did not pop queue");

endmodule : usm_sync_top
`default_nettype wire

// file: include/usm_pkg.sv
package usm_pkg;

  // Register map, one aligned word each
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_BAUD_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RX_STATUS_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR_HIGH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TX_STATUS_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BC_AUTO_BAUD = 0;
  localparam int BC_WAKE = 1;
  localparam int BC_WIDE = 3;
  localparam int BC_POLARITY = 4;
  localparam int BC_RX_IDLE = 6;
  localparam int RC_NINTH_BIT = 0;
  localparam int RC_OVERRUN = 1;
  localparam int RC_FRAMING = 2;
  localparam int RC_CONT_RX = 4;
  localparam int RC_SINGLE_RX = 5;
  localparam int RC_RX_NINE = 6;
  localparam int RC_PORT_EN = 7;
  localparam int TC_TX_NINTH_BIT = 0;
  localparam int TC_SHIFT_EMPTY = 1;
  localparam int TC_SEND_BREAK = 3;
  localparam int TC_SYNC_MODE = 4;
  localparam int TC_TX_ENABLE = 5;
  localparam int TC_TX_NINE = 6;
  localparam int TC_CLK_SRC = 7;
  localparam int FL_TX_EMPTY = 0;
  localparam int FL_RX_CHAR = 1;
  localparam int FE_FRAMING = 9;

  // Writable bits and reset values
  localparam logic [7:0] BC_WMASK = 8'h1B;
  localparam logic [7:0] RC_WMASK = 8'hF0;
  localparam logic [7:0] TC_WMASK = 8'hFD;
  localparam logic [7:0] CTL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame shapes, LSB first
  localparam logic [13:0] BRK_FRAME = 14'h2000;
  localparam logic [3:0] BRK_BITS = 4'hE;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] ASYNC_BITS_8 = 4'hA;
  localparam logic [3:0] ASYNC_BITS_9 = 4'hB;

  localparam int unsigned FIFO_W = 10;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX, ST_WAKE} usm_state_t;

endpackage : usm_pkg

// file: include/usm_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usm_fifo_if #(parameter int unsigned W = 10);
  logic push;
  logic pop;
  logic clr;
  logic [W-1:0] wdata;
  logic [W-1:0] top;
  logic [1:0] count;
  modport owner (output push, output pop, output clr, output wdata, input top, input count);
  modport store (input push, input pop, input clr, input wdata, output top, output count);
endinterface : usm_fifo_if
`default_nettype wire

// file: rtl/usm_rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module usm_rx_fifo #(
  parameter int unsigned W = 10
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  usm_fifo_if.store f
);
  import usm_pkg::*;

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
  } usm_fifo_t;

  usm_fifo_t s;
  usm_fifo_t n;

  // Top entry is a register, so read data never passes through a mux of the store
  always_comb begin
    n = s;
    if (f.clr) begin
      n.cnt = 2'h0;
    end else begin
      if (f.pop && s.cnt != 2'h0) begin
        n.e0 = s.e1;
        n.cnt = s.cnt - 2'h1;
      end
      if (f.push && n.cnt != FIFO_DEPTH) begin
        if (n.cnt == 2'h0) begin
          n.e0 = f.wdata;
        end else begin
          n.e1 = f.wdata;
        end
        n.cnt = n.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign f.top = s.e0;
  assign f.count = s.cnt;

endmodule : usm_rx_fifo
`default_nettype wire

// file: verif/usm_sync_partner.sv
`timescale 1ns/1ps
`default_nettype none
module usm_sync_partner (
  input wire logic ck_w,
  input wire logic dt_oe_i,
  input wire logic dt_w,
  output logic dt_o
);
  logic [7:0] sh = 8'h00;
  logic [7:0] val = 8'h3C;
  int ntx = 0;
  int nrx = 0;
  int nclk = 0;
  logic [7:0] got[$];
  initial dt_o = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Leading edge: next bit LSB first, plain bits with no framing
  always @(posedge ck_w) begin
    nclk++;
    // Drive only while the device has let go of the line
    if (dt_oe_i === 1'b0) begin
      dt_o <= val[ntx];
      ntx = (ntx + 1) % 8;
      if (ntx == 0) val = val + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Trailing edge: sample what the device sends
  always @(negedge ck_w) begin
    if (dt_oe_i === 1'b1) begin
      sh = {dt_w, sh[7:1]};
      nrx++;
      if (nrx == 8) begin
        got.push_back(sh);
        nrx = 0;
      end
    end
  end
endmodule : usm_sync_partner
`default_nettype wire

// file: verif/usm_sync_master_and_break_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module usm_sync_master_and_break_tb_top;
  import usm_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ck_o, ck_oe_o, dt_o, dt_oe_o, pdt, ck_w, dt_w, err;
  logic [31:0] r;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  int lowc = 0;
  int lowmax = 0;
  // Master mode only, so the clock line idles low when nobody drives it
  assign ck_w = ck_oe_o ? ck_o : 1'b0;
  assign dt_w = dt_oe_o ? dt_o : pdt;
  always #50 clk_i = ~clk_i;
  // Longest driven low run while no link clock is driven, so only async frames count
  always @(posedge clk_i) lowc <= (dt_oe_o && !ck_oe_o && !dt_o) ? lowc + 1 : 0;
  always @(posedge clk_i) if (lowc > lowmax) lowmax <= lowc;
  usm_sync_top usm_sync_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ck_i(ck_w),
    .ck_o(ck_o), .ck_oe_o(ck_oe_o), .dt_i(dt_w), .dt_o(dt_o), .dt_oe_o(dt_oe_o));
  usm_sync_partner usm_sync_partner_i (.ck_w(ck_w), .dt_oe_i(dt_oe_o), .dt_w(dt_w),
    .dt_o(pdt));
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      stop_test();
    end
    r = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded poll of one status bit
  task poll(input logic [7:0] a, input int b);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, a, 32'h0);
      if (r[b] === 1'b1) break;
    end
    if (k == 300) begin
      num_errors++;
      stop_test();
    end
  endtask : poll
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, OFF_RX_STATUS_CONTROL, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    // Divisor 3 gives a link clock of 800 ns
    apb(1'b1, OFF_BAUD_DIVISOR_LOW, 32'h3);
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'h80);
    apb(1'b1, OFF_TX_STATUS_CONTROL, 32'hB0);
    apb(1'b1, OFF_TX_DATA, 32'hA5);
    apb(1'b1, OFF_TX_DATA, 32'h5A);
    for (n = 0; n < 400 && usm_sync_partner_i.got.size() < 2; n++) @(posedge clk_i);
    if (n == 400) begin
      num_errors++;
      stop_test();
    end
    repeat (10) @(posedge clk_i);
    `CHK(usm_sync_partner_i.got[0], 8'hA5)
    `CHK(usm_sync_partner_i.got[1], 8'h5A)
    `CHK(usm_sync_partner_i.nclk, 16)
    `CHK(ck_o, 1'b0)
    apb(1'b0, OFF_FLAGS, 32'h0);
    `CHK(r[FL_TX_EMPTY], 1'b1)
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'hA0);
    repeat (8) @(posedge clk_i);
    `CHK(dt_oe_o, 1'b0)
    poll(OFF_FLAGS, FL_RX_CHAR);
    apb(1'b0, OFF_RX_STATUS_CONTROL, 32'h0);
    `CHK(r, 32'h80)
    apb(1'b0, OFF_RX_DATA, 32'h0);
    `CHK(r, 32'h3C)
    apb(1'b0, OFF_FLAGS, 32'h0);
    `CHK(r[FL_RX_CHAR], 1'b0)
    // Continuous receive runs into overrun; stored pair must survive
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'h90);
    poll(OFF_RX_STATUS_CONTROL, RC_OVERRUN);
    apb(1'b0, OFF_RX_DATA, 32'h0);
    `CHK(r, 32'h3D)
    apb(1'b0, OFF_RX_DATA, 32'h0);
    `CHK(r, 32'h3E)
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'h80);
    apb(1'b0, OFF_RX_STATUS_CONTROL, 32'h0);
    `CHK(r, 32'h80)
    // Clearing continuous receive mid-character drops the partial one
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'h90);
    repeat (20) @(posedge clk_i);
    apb(1'b1, OFF_RX_STATUS_CONTROL, 32'h80);
    @(posedge clk_i);
    `CHK(ck_o, 1'b0)
    apb(1'b0, OFF_FLAGS, 32'h0);
    `CHK(r[FL_RX_CHAR], 1'b0)
    // Async header: break, then the sync byte queued behind it
    apb(1'b1, OFF_TX_STATUS_CONTROL, 32'h28);
    apb(1'b1, OFF_TX_DATA, 32'h00);
    apb(1'b1, OFF_TX_DATA, 32'h55);
    poll(OFF_FLAGS, FL_TX_EMPTY);
    apb(1'b0, OFF_TX_STATUS_CONTROL, 32'h0);
    `CHK(r, 32'h20)
    // Start bit and twelve zeros, eight clocks per bit at divisor 3
    `CHK(lowmax, 13 * 8)
    stop_test();
  end
endmodule : usm_sync_master_and_break_tb_top
`default_nettype wire
